// ==== okd_cfg.svh ====
/*
  Offsets, field positions, reset values and timing figures of the
  optical keypad and display controller.
  Assumes inclusion by bare name from the controller module.
*/
`ifndef OKD_CFG_SVH
`define OKD_CFG_SVH
// Register byte offsets
`define OKD_A_CTRL  8'h00
`define OKD_A_STAT  8'h04
`define OKD_A_PIN   8'h08
`define OKD_A_VAL   8'h0c
`define OKD_A_IST   8'h10
`define OKD_A_IMSK  8'h14
// Control field positions
`define OKD_F_BL    1:0
`define OKD_F_EC    3:2
`define OKD_F_ORI   5:4
// Reset values and PIN upper limit
`define OKD_RST_BL  2'h1
`define OKD_RST_EC  2'h2
`define OKD_RST_PIN 14'h0000
`define OKD_PIN_MAX 14'h270f
// Timing figures
`define OKD_CLK_KHZ 25000
`define OKD_DEB_MS  20
`define OKD_HOLD_MS 1000
`define OKD_RPT_MS  200
`define OKD_BLK_MS  500
`define OKD_STUCK_S 70
`define OKD_IDLE_S  60
// Panel geometry and layout rows
`define OKD_W       96
`define OKD_H       64
`define OKD_ROW_VAL 12
`define OKD_ROW_BAR 44
`define OKD_ROW_SYM 54
`endif

// ==== okd_pkg.sv ====
/*
  Types of the optical keypad and display controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package okd_pkg;
  typedef enum logic [1:0] {
    OKD_MON  = 2'h0,
    OKD_DIAG = 2'h1,
    OKD_PIN  = 2'h2,
    OKD_PROG = 2'h3
  } okd_view_t;
  typedef enum logic [1:0] {
    OKD_OFF   = 2'h0,
    OKD_WHITE = 2'h1,
    OKD_RED   = 2'h2
  } okd_col_t;
  typedef enum logic [2:0] {
    OKD_HEAD  = 3'h0,
    OKD_VALUE = 3'h1,
    OKD_BAR   = 3'h2,
    OKD_RANGE = 3'h3,
    OKD_BIG   = 3'h4,
    OKD_SCRL  = 3'h5,
    OKD_SYMS  = 3'h6
  } okd_reg_t;
  typedef struct packed {
    logic [2:0]  s1, s2, s3, cand, btn, bprev, pk;
    logic [31:0] db, hold, rpt, stk, idle, blk;
    logic        held, swal, blind, cancel, blink, err_d, ld, commit, reinit;
    okd_view_t   view;
    logic [3:0]  pv, sel, wsel;
    logic [15:0] val, wval;
    logic [13:0] pin, guess;
    logic [1:0]  bl, ec, ori, bl_o;
    logic [2:0]  ist, imsk;
    okd_reg_t    rg;
    logic [31:0] prdata;
    logic [6:0]  px;
    logic [5:0]  py;
    logic [8:0]  sym;
  } okd_state_t;
endpackage : okd_pkg

// ==== okd_ui.sv ====
/*
  Optical keypad gesture decoder, view controller, backlight and
  display addressing, with an APB register slave.
  Assumes buttons arrive asynchronously; store and status inputs are
  on pclk.
*/
// Added by the designer: the APB interface to the registers and the address map.
// Behaviour
// - Press held over 70 s counts false; detection state reinitialises, as at power-on.
// - Monitoring view: short up shows the next process variable.
// - Monitoring view: short down shows the previous process variable.
// - Menu: short up increments, short down decrements, not under write protect.
// - Menu: holding up or down repeats the step, not under write protect.
// - Enter commits the shown value and selects the next parameter; the code skips the commit under write protect.
// - Exit drops the edited value and selects the previous parameter.
// - Holding up and down together enters the menu in programming view.
// - While error flashing is on, the first press only stops it.
// - Steady backlight and error colour each select red, white or off.
// - Symbols bar shows keys, saving, lock, trend and traffic icons.
// - Pixel array is 96 by 64, drawn in four 90-degree orientations.
// - Monitoring layout: tag top, value and bar graph, symbols bottom.
// - Programming layout: name top, value, range and units, scrolling help.
// - Diagnostics layout: tag top, large message, scrolling text, symbols.
// - Finishing the menu or an idle timeout returns to monitoring view.
// - A nonzero PIN must be entered before the menu; zero disables it.
`include "okd_cfg.svh"
module okd_ui #(
  parameter int unsigned PV_N      = 4,
  parameter int unsigned PAR_N     = 8,
  parameter int unsigned DEB_CYC   = `OKD_DEB_MS * `OKD_CLK_KHZ,
  parameter int unsigned HOLD_CYC  = `OKD_HOLD_MS * `OKD_CLK_KHZ,
  parameter int unsigned RPT_CYC   = `OKD_RPT_MS * `OKD_CLK_KHZ,
  parameter int unsigned BLK_CYC   = `OKD_BLK_MS * `OKD_CLK_KHZ,
  parameter int unsigned STUCK_CYC = `OKD_STUCK_S * 1000 * `OKD_CLK_KHZ,
  parameter int unsigned IDLE_CYC  = `OKD_IDLE_S * 1000 * `OKD_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Optical buttons: up, down, enter
  input  wire logic [2:0]  btn_raw,
  output logic             reinit,
  // Configuration store
  input  wire logic        wp_in,
  input  wire logic        cfg_busy,
  input  wire logic [15:0] cfg_rdata,
  output logic      [3:0]  cfg_rsel,
  output logic             cfg_we,
  output logic      [3:0]  cfg_wsel,
  output logic      [15:0] cfg_wdata,
  // Device status
  input  wire logic        err_in,
  input  wire logic        trend_in,
  input  wire logic        hart_act,
  input  wire logic        int_act,
  input  wire logic        hart_err,
  // Display
  input  wire logic [6:0]  lx,
  input  wire logic [6:0]  ly,
  output logic      [6:0]  px,
  output logic      [5:0]  py,
  output okd_pkg::okd_reg_t region,
  output logic      [8:0]  sym,
  output logic      [1:0]  bl_col,
  output okd_pkg::okd_view_t view,
  output logic      [3:0]  pv
);
  okd_pkg::okd_state_t s;
  okd_pkg::okd_state_t next_s;
  logic rise;
  logic rel;
  logic hold_ev;
  logic rpt_ev;
  logic up;
  logic dn;
  logic ent;
  logic ext;
  logic cmb;
  logic flash;
  logic stuck;
  logic wr;
  logic rd;
  logic hit;
  logic [2:0] ev;

  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    next_s.commit = 1'b0;
    next_s.reinit = 1'b0;
    // Synchroniser and debounce; a change counts once stages two and three agree and the debounce count then reaches DEB_CYC - 1
    next_s.s1 = btn_raw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3 && s.s3 != s.cand)
    begin
      next_s.cand = s.s3;
      next_s.db = 32'h0;
    end
    else if (s.db != DEB_CYC - 1)
      next_s.db = s.db + 32'h1;
    else
    begin
      next_s.btn = s.blind ? 3'h0 : s.cand;
      if (s.cand == 3'h0)
        next_s.blind = 1'b0;
    end
    next_s.bprev = s.btn;
    rise = |(s.btn & ~s.bprev);
    rel = s.btn == 3'h0 && s.bprev != 3'h0;
    // Gesture timing
    next_s.pk = rel ? 3'h0 : s.pk | s.btn;
    hold_ev = s.btn != 3'h0 && s.btn == s.bprev && !s.held
              && s.hold == HOLD_CYC - 1 && !s.swal;
    if (s.btn == 3'h0 || s.btn != s.bprev)
      next_s.hold = 32'h0;
    else if (s.hold != HOLD_CYC - 1)
      next_s.hold = s.hold + 32'h1;
    if (hold_ev)
      next_s.held = 1'b1;
    if (rel)
    begin
      next_s.held = 1'b0;
      next_s.swal = 1'b0;
    end
    rpt_ev = s.held && s.btn == s.bprev && s.rpt == RPT_CYC - 1 && !s.swal;
    if (!s.held || s.btn != s.bprev || rpt_ev)
      next_s.rpt = 32'h0;
    else
      next_s.rpt = s.rpt + 32'h1;
    up = ((rel && !s.held && !s.swal && s.pk == 3'h1)
         || ((hold_ev || rpt_ev) && s.btn == 3'h1));
    dn = ((rel && !s.held && !s.swal && s.pk == 3'h2)
         || ((hold_ev || rpt_ev) && s.btn == 3'h2));
    ent = rel && !s.held && !s.swal && s.pk == 3'h4;
    ext = hold_ev && s.btn == 3'h4;
    cmb = hold_ev && s.btn == 3'h3;
    // False press watchdog
    stuck = s.btn != 3'h0 && s.stk == STUCK_CYC - 1;
    next_s.stk = (s.btn == 3'h0 || stuck) ? 32'h0 : s.stk + 32'h1;
    if (stuck)
    begin
      next_s.reinit = 1'b1;
      next_s.blind = 1'b1;
      next_s.btn = 3'h0;
      next_s.bprev = 3'h0;
      next_s.pk = 3'h0;
      next_s.held = 1'b0;
      next_s.swal = 1'b0;
      next_s.hold = 32'h0;
      next_s.db = 32'h0;
    end
    // Error flashing; first press only cancels it
    next_s.err_d = err_in;
    flash = err_in && s.ec != 2'(okd_pkg::OKD_OFF) && !s.cancel;
    if (!err_in)
      next_s.cancel = 1'b0;
    else if (flash && rise)
    begin
      next_s.cancel = 1'b1;
      next_s.swal = 1'b1;
    end
    next_s.blk = (s.blk == BLK_CYC - 1) ? 32'h0 : s.blk + 32'h1;
    if (s.blk == BLK_CYC - 1)
      next_s.blink = ~s.blink;
    next_s.bl_o = flash ? (s.blink ? s.ec : 2'(okd_pkg::OKD_OFF)) : s.bl;
    // Inactivity timer
    next_s.idle = (s.btn != 3'h0) ? 32'h0 : s.idle + 32'h1;
    if (s.ld)
    begin
      next_s.val = cfg_rdata;
      next_s.ld = 1'b0;
    end
    // View machine
    case (s.view)
      okd_pkg::OKD_MON, okd_pkg::OKD_DIAG:
      begin
        next_s.view = err_in ? okd_pkg::OKD_DIAG : okd_pkg::OKD_MON;
        if (up)
          next_s.pv = (s.pv == 4'(PV_N - 1)) ? 4'h0 : s.pv + 4'h1;
        else if (dn)
          next_s.pv = (s.pv == 4'h0) ? 4'(PV_N - 1) : s.pv - 4'h1;
        else if (cmb)
        begin
          next_s.idle = 32'h0;
          next_s.sel = 4'h0;
          next_s.ld = 1'b1;
          next_s.guess = 14'h0;
          next_s.view = (s.pin != 14'h0) ? okd_pkg::OKD_PIN : okd_pkg::OKD_PROG;
        end
      end
      okd_pkg::OKD_PIN:
      begin
        if (up)
          next_s.guess = (s.guess == `OKD_PIN_MAX) ? 14'h0 : s.guess + 14'h1;
        else if (dn)
          next_s.guess = (s.guess == 14'h0) ? `OKD_PIN_MAX : s.guess - 14'h1;
        else if (ent)
          next_s.view = (s.guess == s.pin) ? okd_pkg::OKD_PROG : okd_pkg::OKD_MON;
        else if (ext || s.idle == IDLE_CYC - 1)
          next_s.view = okd_pkg::OKD_MON;
      end
      okd_pkg::OKD_PROG:
      begin
        if (up && !wp_in && !s.ld)
          next_s.val = s.val + 16'h1;
        else if (dn && !wp_in && !s.ld)
          next_s.val = s.val - 16'h1;
        else if (ent)
        begin
          next_s.commit = !wp_in;
          next_s.wsel = s.sel;
          next_s.wval = s.val;
          next_s.ld = 1'b1;
          if (s.sel == 4'(PAR_N - 1))
            next_s.view = okd_pkg::OKD_MON;
          else
            next_s.sel = s.sel + 4'h1;
        end
        else if (ext)
        begin
          next_s.ld = 1'b1;
          if (s.sel == 4'h0)
            next_s.view = okd_pkg::OKD_MON;
          else
            next_s.sel = s.sel - 4'h1;
        end
        else if (s.idle == IDLE_CYC - 1)
          next_s.view = okd_pkg::OKD_MON;
      end
      default:
        next_s.view = okd_pkg::OKD_MON;
    endcase
    // Symbols bar: up, down, enter, save, lock, trend, hart, int, hart error
    next_s.sym = {hart_err, int_act, hart_act, trend_in, wp_in, cfg_busy,
                  s.btn[2], s.btn[1], s.btn[0]};
    // Orientation mapping onto the fixed panel
    case (s.ori)
      2'h1:
      begin
        next_s.px = 7'(`OKD_W - 1 - (`OKD_W - `OKD_H) / 2) - ly;
        next_s.py = lx[5:0];
      end
      2'h2:
      begin
        next_s.px = 7'(`OKD_W - 1) - lx;
        next_s.py = 6'(`OKD_H - 1) - ly[5:0];
      end
      2'h3:
      begin
        next_s.px = 7'((`OKD_W - `OKD_H) / 2) + ly;
        next_s.py = 6'(`OKD_H - 1) - lx[5:0];
      end
      default:
      begin
        next_s.px = lx;
        next_s.py = ly[5:0];
      end
    endcase
    // Screen layout by view and row
    if (ly < 7'(`OKD_ROW_VAL))
      next_s.rg = okd_pkg::OKD_HEAD;
    else if (ly < 7'(`OKD_ROW_BAR))
      next_s.rg = (s.view == okd_pkg::OKD_DIAG) ? okd_pkg::OKD_BIG : okd_pkg::OKD_VALUE;
    else if (ly < 7'(`OKD_ROW_SYM))
    begin
      case (s.view)
        okd_pkg::OKD_MON:  next_s.rg = okd_pkg::OKD_BAR;
        okd_pkg::OKD_DIAG: next_s.rg = okd_pkg::OKD_SCRL;
        default:           next_s.rg = okd_pkg::OKD_RANGE;
      endcase
    end
    else
      next_s.rg = (s.view == okd_pkg::OKD_MON || s.view == okd_pkg::OKD_DIAG)
                  ? okd_pkg::OKD_SYMS : okd_pkg::OKD_SCRL;
    // APB slave; read data is captured in the setup cycle
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    hit = paddr == `OKD_A_CTRL || paddr == `OKD_A_STAT || paddr == `OKD_A_PIN
          || paddr == `OKD_A_VAL || paddr == `OKD_A_IST || paddr == `OKD_A_IMSK;
    ev = {err_in && !s.err_d, s.reinit, s.commit};
    next_s.ist = s.ist | ev;
    if (wr && paddr == `OKD_A_CTRL)
    begin
      next_s.bl = pwdata[`OKD_F_BL];
      next_s.ec = pwdata[`OKD_F_EC];
      next_s.ori = pwdata[`OKD_F_ORI];
    end
    if (wr && paddr == `OKD_A_PIN)
      next_s.pin = pwdata[13:0];
    if (wr && paddr == `OKD_A_IST)
      next_s.ist = (s.ist & ~pwdata[2:0]) | ev;
    if (wr && paddr == `OKD_A_IMSK)
      next_s.imsk = pwdata[2:0];
    if (rd)
    begin
      case (paddr)
        `OKD_A_CTRL: next_s.prdata = {26'h0, s.ori, s.ec, s.bl};
        `OKD_A_STAT: next_s.prdata = {20'h0, wp_in, flash, s.sel, s.pv, s.view};
        `OKD_A_PIN:  next_s.prdata = {18'h0, s.pin};
        `OKD_A_VAL:  next_s.prdata = {16'h0, s.val};
        `OKD_A_IST:  next_s.prdata = {29'h0, s.ist};
        `OKD_A_IMSK: next_s.prdata = {29'h0, s.imsk};
        default:     next_s.prdata = 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.bl <= `OKD_RST_BL;
      s.ec <= `OKD_RST_EC;
      s.pin <= `OKD_RST_PIN;
      s.view <= okd_pkg::OKD_MON;
      s.rg <= okd_pkg::OKD_HEAD;
    end
    else
      s <= next_s;
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign irq = |(s.ist & s.imsk);
  assign reinit = s.reinit;
  assign cfg_rsel = s.sel;
  assign cfg_we = s.commit;
  assign cfg_wsel = s.wsel;
  assign cfg_wdata = s.wval;
  assign px = s.px;
  assign py = s.py;
  assign region = s.rg;
  assign sym = s.sym;
  assign bl_col = s.bl_o;
  assign view = s.view;
  assign pv = s.pv;

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_stuck_reinit: assert property (stuck |=> s.reinit && s.btn == 3'h0 && s.blind)
    else $error("false press not reinitialised");
  a_pv_next: assert property ((s.view == okd_pkg::OKD_MON && up && s.pv != 4'(PV_N - 1))
    |=> s.pv == $past(s.pv) + 4'h1)
    else $error("up did not advance variable");
  a_pv_prev: assert property ((s.view == okd_pkg::OKD_MON && dn && s.pv != 4'h0)
    |=> s.pv == $past(s.pv) - 4'h1)
    else $error("down did not step variable back");
  a_wp_freeze: assert property ((s.view == okd_pkg::OKD_PROG && wp_in && !s.ld)
    |=> $stable(s.val))
    else $error("value changed under write protect");
  a_hold_step: assert property ((s.view == okd_pkg::OKD_PROG && rpt_ev && s.btn == 3'h1
    && !wp_in && !s.ld) |=> s.val == $past(s.val) + 16'h1)
    else $error("hold repeat did not step");
  a_enter_commit: assert property ((s.view == okd_pkg::OKD_PROG && ent && !wp_in)
    |=> cfg_we && cfg_wsel == $past(s.sel) && cfg_wdata == $past(s.val))
    else $error("enter did not commit");
  a_exit_back: assert property ((s.view == okd_pkg::OKD_PROG && ext && s.sel != 4'h0)
    |=> s.sel == $past(s.sel) - 4'h1 && s.ld ##1 s.val == $past(cfg_rdata))
    else $error("exit did not reload previous");
  a_combo_menu: assert property ((s.view == okd_pkg::OKD_MON && cmb && s.pin == 14'h0)
    |=> s.view == okd_pkg::OKD_PROG && s.sel == 4'h0)
    else $error("combo hold missed menu");
  a_flash_swallow: assert property ((flash && rise) |=> s.swal && s.cancel)
    else $error("flash cancel press not swallowed");
  a_swal_mute: assert property (s.swal |-> !up && !dn && !ent && !ext && !cmb)
    else $error("swallowed press acted");
  a_pin_gate: assert property ((s.view == okd_pkg::OKD_MON && cmb && s.pin != 14'h0)
    |=> s.view == okd_pkg::OKD_PIN)
    else $error("menu entered without pin");
  a_idle_home: assert property ((s.view == okd_pkg::OKD_PROG && s.idle == IDLE_CYC - 1
    && !up && !dn && !ent && !ext) |=> s.view == okd_pkg::OKD_MON)
    else $error("idle timeout missed");
  c_menu_entry: cover property (s.view == okd_pkg::OKD_MON ##1 s.view == okd_pkg::OKD_PROG);
  c_commit: cover property (cfg_we);
  c_flash_cancel: cover property (flash ##1 s.cancel);
  c_reinit: cover property (s.reinit);
endmodule : okd_ui

// ==== okd_oper.sv ====
/*
  Operator model: a finger over the three optical buttons.
  Assumes the bench calls press from its main process.
*/
module okd_oper (
  // Clock
  input  wire logic       pclk,
  // Buttons: up, down, enter
  output logic      [2:0] btn_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial btn_raw = 3'h0;
  //////////////////////////////////////////////////////////////////////
  // Hold a pattern for n cycles, then lift the finger fully
  task automatic press(input logic [2:0] pat, input int n);
    @(posedge pclk);
    btn_raw <= pat;
    repeat (n) @(posedge pclk);
    btn_raw <= 3'h0;
    repeat (24) @(posedge pclk);
  endtask : press
endmodule : okd_oper

// ==== okd_tb.sv ====
/*
  Self-checking bench of the keypad and display controller.
  Assumes shortened timing parameters and a small parameter store.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd, val0, last_we;
  logic [2:0]          btn_raw;
  logic                reinit, wp_in, cfg_busy, cfg_we, err_in, trend_in;
  logic                hart_act, int_act, hart_err, last_err, seen_r, seen_o;
  logic [15:0]         cfg_rdata, cfg_wdata;
  logic [15:0]         store [16];
  logic [3:0]          cfg_rsel, cfg_wsel, pv;
  logic [6:0]          lx, ly, px;
  logic [5:0]          py;
  logic [8:0]          sym;
  logic [1:0]          bl_col;
  okd_pkg::okd_reg_t   region;
  okd_pkg::okd_view_t  view;
  logic [6:0]          rows [6] = '{7'h11, 7'h12, 7'h21, 7'h20, 7'h23, 7'h10};
  int                  err_count, checks, n_we, n_reinit;
  //////////////////////////////////////////////////////////////////////
  okd_ui #(.DEB_CYC(4), .HOLD_CYC(40), .RPT_CYC(8), .BLK_CYC(16), .STUCK_CYC(400),
    .IDLE_CYC(1000)) okd_ui_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .btn_raw(btn_raw), .reinit(reinit), .wp_in(wp_in), .cfg_busy(cfg_busy),
    .cfg_rdata(cfg_rdata), .cfg_rsel(cfg_rsel), .cfg_we(cfg_we), .cfg_wsel(cfg_wsel),
    .cfg_wdata(cfg_wdata), .err_in(err_in), .trend_in(trend_in), .hart_act(hart_act),
    .int_act(int_act), .hart_err(hart_err), .lx(lx), .ly(ly), .px(px), .py(py),
    .region(region), .sym(sym), .bl_col(bl_col), .view(view), .pv(pv));
  okd_oper okd_oper_i (.pclk(pclk), .btn_raw(btn_raw));
  //////////////////////////////////////////////////////////////////////
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  assign cfg_rdata = store[cfg_rsel];
  // Store model and event counters
  always @(posedge pclk)
  begin
    if (cfg_we === 1'b1)
    begin
      n_we++;
      last_we <= {12'h000, cfg_wsel, cfg_wdata};
      store[cfg_wsel] <= cfg_wdata;
    end
    if (reinit === 1'b1)
      n_reinit++;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write settle before outputs are sampled
    @(posedge pclk);
  endtask : apb
  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    #800000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, wp_in, cfg_busy, err_in} = '0;
    {trend_in, hart_act, int_act, hart_err, lx, ly, n_we, n_reinit} = '0;
    for (int i = 0; i < 16; i++)
      store[i] = 16'h0100 + 16'(i);
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd, last_err}, 33'h1);
    // Geometry, upright and turned half round
    lx <= 7'h05;
    ly <= 7'h07;
    repeat (3) @(posedge pclk);
    chk({px, py, region}, {7'h05, 6'h07, okd_pkg::OKD_HEAD});
    ly <= 7'h32;
    repeat (3) @(posedge pclk);
    chk(region, okd_pkg::OKD_BAR);
    apb(1'b1, 8'h00, 32'h0000_0029);
    ly <= 7'h07;
    repeat (3) @(posedge pclk);
    chk({px, py}, {7'h5a, 6'h38});
    apb(1'b1, 8'h00, 32'h0000_0009);
    for (int i = 0; i < 6; i++)
    begin
      okd_oper_i.press(rows[i][6:4], 10);
      chk(pv, rows[i][3:0]);
    end
    wp_in <= 1'b1;
    trend_in <= 1'b1;
    int_act <= 1'b1;
    fork
      okd_oper_i.press(3'h1, 10);
      begin
        repeat (12) @(posedge pclk);
        chk(sym, 9'h0b1);
        wp_in <= 1'b0;
        trend_in <= 1'b0;
        int_act <= 1'b0;
        cfg_busy <= 1'b1;
        hart_act <= 1'b1;
        hart_err <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(sym, 9'h149);
      end
    join
    cfg_busy <= 1'b0;
    hart_act <= 1'b0;
    hart_err <= 1'b0;
    // Error flash, first press only cancels it
    apb(1'b1, 8'h14, 32'h4);
    err_in <= 1'b1;
    {seen_r, seen_o} = 2'b00;
    repeat (48) @(posedge pclk)
    begin
      seen_r |= (bl_col === 2'h2);
      seen_o |= (bl_col === 2'h0);
    end
    chk({view, irq, seen_r, seen_o}, {okd_pkg::OKD_DIAG, 3'h7});
    okd_oper_i.press(3'h1, 10);
    chk({pv, bl_col}, {4'h1, 2'h1});
    apb(1'b1, 8'h10, 32'h4);
    chk(irq, 1'b0);
    err_in <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(view, okd_pkg::OKD_MON);
    // Menu entry and editing
    okd_oper_i.press(3'h3, 60);
    chk({view, cfg_rsel}, {okd_pkg::OKD_PROG, 4'h0});
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_0007);
    okd_oper_i.press(3'h1, 10);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h101);
    okd_oper_i.press(3'h2, 10);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h100);
    wp_in <= 1'b1;
    okd_oper_i.press(3'h1, 10);
    okd_oper_i.press(3'h1, 70);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h100);
    wp_in <= 1'b0;
    okd_oper_i.press(3'h1, 70);
    apb(1'b0, 8'h0c, 32'h0);
    val0 = rd;
    chk(val0, 32'h104);
    okd_oper_i.press(3'h4, 10);
    chk({n_we, last_we, 28'(cfg_rsel)}, {32'd1, val0, 28'h1});
    okd_oper_i.press(3'h4, 60);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd, 28'(cfg_rsel)}, {val0, 28'h0});
    repeat (1100) @(posedge pclk);
    chk(view, okd_pkg::OKD_MON);
    apb(1'b1, 8'h08, 32'h5);
    okd_oper_i.press(3'h3, 60);
    chk(view, okd_pkg::OKD_PIN);
    okd_oper_i.press(3'h4, 60);
    chk(view, okd_pkg::OKD_MON);
    // Correct PIN opens the menu
    okd_oper_i.press(3'h3, 60);
    for (int i = 0; i < 5; i++)
      okd_oper_i.press(3'h1, 10);
    okd_oper_i.press(3'h4, 10);
    chk(view, okd_pkg::OKD_PROG);
    okd_oper_i.press(3'h4, 60);
    chk(view, okd_pkg::OKD_MON);
    apb(1'b1, 8'h08, 32'h0);
    // Stuck press, masked then unmasked
    apb(1'b1, 8'h14, 32'h0);
    okd_oper_i.press(3'h4, 450);
    chk({n_reinit, irq}, {32'd1, 1'b0});
    apb(1'b1, 8'h14, 32'h2);
    chk(irq, 1'b1);
    apb(1'b1, 8'h10, 32'h2);
    chk(irq, 1'b0);
    // Error colour off: steady red backlight, no flashing
    apb(1'b1, 8'h00, 32'h0000_0002);
    err_in <= 1'b1;
    ly <= 7'h20;
    seen_o = 1'b0;
    repeat (40) @(posedge pclk)
      seen_o |= (bl_col !== 2'h2);
    chk({seen_o, irq, region}, {2'b00, okd_pkg::OKD_BIG});
    err_in <= 1'b0;
    test_done();
  end
endmodule : testbench
